// ### rtl/ite_master.sv
// Contract
// - master only, bus clocked at 100 kHz
// - slaves selected by their seven-bit address
// - write: START, address, direction bit low
// - write address not acknowledged: STOP, abandon
// - write sends count bytes from start index
// - fully acked write ends without STOP, bus held
// - read may follow held write directly
// - result flag 1 acked, 0 otherwise
// - read: START, address, direction bit high
// - read address not acknowledged: STOP, abandon
// - master clocks, slave shifts bits out
// - acknowledge every read byte except last
// - last read byte unacknowledged, then STOP
// - read bytes stored from start index onward
`timescale 1ns/1ps
module ite_master #(
   parameter int unsigned QUARTER_CYCLES = ite_pkg::QUARTER_CYC,  // Quarter bit time
   parameter int unsigned TIMEOUT_CYCLES = ite_pkg::TIMEOUT_CYC   // Stretch timeout
) (
   input  wire logic                       clock,         // 250 MHz clock
   input  wire logic                       resetn,        // Async reset, active low
   input  wire ite_pkg::ite_cmd_type       cmd,           // Command fields
   input  wire logic                       cmd_valid,     // Command offered
   output logic                            cmd_ready,     // Command taken when both high
   output logic                            done,          // Transfer finished pulse
   output logic                            result,        // 1 acked, 0 failed
   output logic                            busy,          // Transfer in progress
   output logic                            bus_held,      // Write left bus open
   input  wire logic                       buf_wr_en,     // User buffer write
   input  wire logic [ite_pkg::IDX_W-1:0]  buf_wr_index,  // User write index
   input  wire logic [7:0]                 buf_wr_data,   // User write byte
   input  wire logic [ite_pkg::IDX_W-1:0]  buf_rd_index,  // User read index
   output logic [7:0]                      buf_rd_data,   // User read byte, registered
   input  wire logic                       scl_i,         // Clock line level
   output logic                            scl_o,         // Clock line drive value
   output logic                            scl_oe,        // Clock line pulled low
   input  wire logic                       sda_i,         // Data line level
   output logic                            sda_o,         // Data line drive value
   output logic                            sda_oe         // Data line pulled low
);

   localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);

   // Data memory buffer
   logic [7:0]                  data_memory_buffer [ite_pkg::BUF_DEPTH];

   ite_pkg::ite_state_type      state_q, state_d;
   ite_pkg::ite_op_type         op_q, op_d;
   logic [1:0]                  qtr_q, qtr_d;
   logic [3:0]                  bit_q, bit_d;
   logic [7:0]                  sh_q, sh_d;
   logic                        addr_phase_q, addr_phase_d;
   logic                        ack_q, ack_d;
   logic [ite_pkg::IDX_W-1:0]   idx_q, idx_d;
   logic [ite_pkg::CNT_W-1:0]   rem_q, rem_d;
   logic                        result_q, result_d;
   logic                        done_q, done_d;
   logic                        scl_oe_q, scl_oe_d;
   logic                        sda_oe_q, sda_oe_d;
   logic [TW-1:0]               tmo_q, tmo_d;
   logic                        eng_we;
   logic                        tick;
   logic                        run;
   logic                        tx;
   logic                        scl_m, scl_s, sda_m, sda_s;

   // Two-stage synchronisers for the shared bus lines
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         sda_m <= sda_i;
         sda_s <= sda_m;
      end
   end

   assign run = (state_q != ite_pkg::ITE_ST_IDLE) && (state_q != ite_pkg::ITE_ST_HOLD);

   ite_tick_gen #(
      .DIV (QUARTER_CYCLES)
   ) u_tick (
      .clock  (clock),
      .resetn (resetn),
      .run    (run),
      .tick   (tick)
   );

   // Address byte and write data are shifted out, read data in
   assign tx = addr_phase_q || (op_q == ite_pkg::ITE_OP_WRITE);

   // Engine next state
   always_comb begin
      state_d      = state_q;
      op_d         = op_q;
      qtr_d        = qtr_q;
      bit_d        = bit_q;
      sh_d         = sh_q;
      addr_phase_d = addr_phase_q;
      ack_d        = ack_q;
      idx_d        = idx_q;
      rem_d        = rem_q;
      result_d     = result_q;
      done_d       = 1'b0;
      scl_oe_d     = scl_oe_q;
      sda_oe_d     = sda_oe_q;
      tmo_d        = '0;
      eng_we       = 1'b0;
      case (state_q)
         ite_pkg::ITE_ST_IDLE, ite_pkg::ITE_ST_HOLD: begin
            if (cmd_valid) begin
               op_d         = cmd.op;
               idx_d        = cmd.start_index;
               rem_d        = cmd.count;
               qtr_d        = 2'h0;
               bit_d        = 4'h0;
               addr_phase_d = 1'b1;
               sh_d         = {cmd.target_address, cmd.op == ite_pkg::ITE_OP_READ};
               // held bus restarts for a read
               if (cmd.op == ite_pkg::ITE_OP_STOP) begin
                  state_d = ite_pkg::ITE_ST_STOP;
               end else begin
                  state_d = ite_pkg::ITE_ST_START;
               end
            end
         end
         ite_pkg::ITE_ST_START: begin
            if (tick) begin
               qtr_d = qtr_q + 2'h1;
               case (qtr_q)
                  2'h0: begin
                     scl_oe_d = 1'b1;
                     sda_oe_d = 1'b0;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  default: begin
                     scl_oe_d = 1'b1;
                     state_d  = ite_pkg::ITE_ST_BIT;
                  end
               endcase
            end
         end
         ite_pkg::ITE_ST_BIT: begin
            // Clock stretching; a slave holding SCL too long aborts
            if (qtr_q == 2'h2 && !scl_s) begin
               tmo_d = tmo_q + TW'(1);
               if (tmo_q >= TW'(TIMEOUT_CYCLES - 1)) begin
                  result_d = 1'b0;
                  state_d  = ite_pkg::ITE_ST_STOP;
                  qtr_d    = 2'h0;
               end
            end else if (tick) begin
               qtr_d = qtr_q + 2'h1;
               case (qtr_q)
                  2'h0: begin
                     scl_oe_d = 1'b1;
                     if (bit_q != ite_pkg::ACK_SLOT) begin
                        sda_oe_d = tx ? ~sh_q[7] : 1'b0;
                     end else begin
                        // ack all but last read byte
                        sda_oe_d = !tx && (rem_q != ite_pkg::CNT_W'(1));
                     end
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin
                     if (bit_q != ite_pkg::ACK_SLOT) begin
                        sh_d = {sh_q[6:0], sda_s};
                     end else begin
                        ack_d = ~sda_s;
                     end
                  end
                  default: begin
                     scl_oe_d = 1'b1;
                     if (bit_q != ite_pkg::ACK_SLOT) begin
                        bit_d = bit_q + 4'h1;
                     end else begin
                        bit_d = 4'h0;
                        if (addr_phase_q) begin
                           addr_phase_d = 1'b0;
                           if (!ack_q) begin
                              result_d = 1'b0;
                              state_d  = ite_pkg::ITE_ST_STOP;
                           end else if (rem_q == '0) begin
                              result_d = 1'b1;
                              if (op_q == ite_pkg::ITE_OP_WRITE) begin
                                 state_d  = ite_pkg::ITE_ST_HOLD;
                                 scl_oe_d = 1'b1;
                                 done_d   = 1'b1;
                              end else begin
                                 state_d = ite_pkg::ITE_ST_STOP;
                              end
                           end else if (op_q == ite_pkg::ITE_OP_WRITE) begin
                              sh_d = data_memory_buffer[idx_q];
                           end
                        end else if (op_q == ite_pkg::ITE_OP_WRITE) begin
                           if (!ack_q) begin
                              result_d = 1'b0;
                              state_d  = ite_pkg::ITE_ST_STOP;
                           end else begin
                              idx_d = idx_q + ite_pkg::IDX_W'(1);
                              rem_d = rem_q - ite_pkg::CNT_W'(1);
                              sh_d  = data_memory_buffer[idx_q + ite_pkg::IDX_W'(1)];
                              if (rem_q == ite_pkg::CNT_W'(1)) begin
                                 result_d = 1'b1;
                                 state_d  = ite_pkg::ITE_ST_HOLD;
                                 scl_oe_d = 1'b1;
                                 done_d   = 1'b1;
                              end
                           end
                        end else begin
                           eng_we = 1'b1;
                           idx_d  = idx_q + ite_pkg::IDX_W'(1);
                           rem_d  = rem_q - ite_pkg::CNT_W'(1);
                           if (rem_q == ite_pkg::CNT_W'(1)) begin
                              result_d = 1'b1;
                              state_d  = ite_pkg::ITE_ST_STOP;
                           end
                        end
                     end
                  end
               endcase
            end
         end
         ite_pkg::ITE_ST_STOP: begin
            if (tick) begin
               qtr_d = qtr_q + 2'h1;
               case (qtr_q)
                  2'h0: begin
                     scl_oe_d = 1'b1;
                     sda_oe_d = 1'b1;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  default: begin
                     state_d = ite_pkg::ITE_ST_IDLE;
                     done_d  = 1'b1;
                  end
               endcase
            end
         end
         default: state_d = ite_pkg::ITE_ST_IDLE;
      endcase
   end

   // Engine registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q      <= ite_pkg::ITE_ST_IDLE;
         op_q         <= ite_pkg::ITE_OP_STOP;
         qtr_q        <= 2'h0;
         bit_q        <= 4'h0;
         sh_q         <= 8'h00;
         addr_phase_q <= 1'b0;
         ack_q        <= 1'b0;
         idx_q        <= '0;
         rem_q        <= '0;
         result_q     <= ite_pkg::RESULT_RST;
         done_q       <= 1'b0;
         scl_oe_q     <= 1'b0;
         sda_oe_q     <= 1'b0;
         tmo_q        <= '0;
      end else begin
         state_q      <= state_d;
         op_q         <= op_d;
         qtr_q        <= qtr_d;
         bit_q        <= bit_d;
         sh_q         <= sh_d;
         addr_phase_q <= addr_phase_d;
         ack_q        <= ack_d;
         idx_q        <= idx_d;
         rem_q        <= rem_d;
         result_q     <= result_d;
         done_q       <= done_d;
         scl_oe_q     <= scl_oe_d;
         sda_oe_q     <= sda_oe_d;
         tmo_q        <= tmo_d;
      end
   end

   // Buffer; engine store wins, user writes only land while not busy
   always_ff @(posedge clock) begin
      if (eng_we) begin
         data_memory_buffer[idx_q] <= sh_q;
      end else if (buf_wr_en && !run) begin
         data_memory_buffer[buf_wr_index] <= buf_wr_data;
      end
      buf_rd_data <= data_memory_buffer[buf_rd_index];
   end

   // Open-drain pins only ever pull low
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_oe    = scl_oe_q;
   assign sda_oe    = sda_oe_q;
   assign done      = done_q;
   assign result    = result_q;
   assign busy      = run;
   assign bus_held  = (state_q == ite_pkg::ITE_ST_HOLD);
   assign cmd_ready = !run;

endmodule // ite_master

// ### rtl/ite_pkg.sv
package ite_pkg;

   // Clock and bus timing
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned BUS_HZ        = 100_000;
   // Four quarter phases per serial bit
   localparam int unsigned QUARTER_CYC   = CLK_HZ / (4 * BUS_HZ);
   // Longest wait on a held-low clock line
   localparam int unsigned TIMEOUT_US    = 1000;
   localparam int unsigned TIMEOUT_CYC   = TIMEOUT_US * (CLK_HZ / 1_000_000);

   // Buffer geometry
   localparam int unsigned IDX_W         = 8;
   localparam int unsigned CNT_W         = 9;
   localparam int unsigned BUF_DEPTH     = 256;

   // Byte framing: eight data bits then one acknowledge slot
   localparam logic [3:0]  ACK_SLOT      = 4'h8;
   localparam logic [1:0]  LAST_QUARTER  = 2'h3;

   // Values after reset
   localparam logic        RESULT_RST    = 1'b0;

   typedef enum logic [1:0] {
      ITE_OP_WRITE,
      ITE_OP_READ,
      ITE_OP_STOP
   } ite_op_type;

   typedef struct packed {
      ite_op_type         op;
      logic [6:0]         target_address;
      logic [IDX_W-1:0]   start_index;
      logic [CNT_W-1:0]   count;
   } ite_cmd_type;

   typedef enum logic [2:0] {
      ITE_ST_IDLE,
      ITE_ST_HOLD,
      ITE_ST_START,
      ITE_ST_BIT,
      ITE_ST_STOP
   } ite_state_type;

endpackage

// ### rtl/ite_tick_gen.sv
`timescale 1ns/1ps
module ite_tick_gen #(
   parameter int unsigned DIV = ite_pkg::QUARTER_CYC
) (
   input  wire logic clock,   // System clock
   input  wire logic resetn,  // Async reset, active low
   input  wire logic run,     // Count while high, clear while low
   output logic      tick     // One-cycle enable each DIV cycles
);

   localparam int unsigned CW = $clog2(DIV + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_d;

   // Divider next state; cleared so phases align to the command
   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
      end else if (cnt_q == CW'(DIV - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + CW'(1);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end

endmodule // ite_tick_gen

// ### verification/ite_master_assertions.sv
`timescale 1ns/1ps
// Port checks on the engine; all in the one clock domain
module ite_master_assertions #(
   parameter int unsigned QUARTER_CYCLES = ite_pkg::QUARTER_CYC  // Quarter bit time
) (
   input wire logic clock,      // System clock
   input wire logic resetn,     // Async reset, active low
   input wire logic cmd_valid,  // Command offered
   input wire logic cmd_ready,  // Command taken
   input wire logic done,       // End pulse
   input wire logic result,     // Ack outcome
   input wire logic busy,       // Transfer running
   input wire logic bus_held,   // Write left bus open
   input wire logic scl_o,      // Clock drive value
   input wire logic scl_oe,     // Clock pulled low
   input wire logic sda_o,      // Data drive value
   input wire logic sda_oe      // Data pulled low
);
   // Sync lag may shave two cycles off a quarter
   localparam int MIN_HOLD  = QUARTER_CYCLES - 2;
   localparam int START_WIN = 2 * QUARTER_CYCLES + 4;
   localparam int STOP_WIN  = 3 * QUARTER_CYCLES + 4;
   logic        prev_q, prev_d;
   logic [15:0] stab_q, stab_d;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Cycles the clock drive has stood still, saturating
   always_comb begin
      prev_d = scl_oe;
      stab_d = (scl_oe != prev_q) ? 16'h0000
             : stab_q + ((stab_q != 16'hFFFF) ? 16'h0001 : 16'h0000);
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
         stab_q <= 16'hFFFF;
      end else begin
         prev_q <= prev_d;
         stab_q <= stab_d;
      end
   end

   property p_rate; scl_oe != prev_q |-> stab_q >= MIN_HOLD; endproperty
   a_rate: assert property (p_rate) else $error("clock edge too soon");
   property p_drain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("line driven high");
   property p_take; cmd_valid && cmd_ready |=> busy; endproperty
   a_take: assert property (p_take) else $error("command not started");
   property p_held; bus_held |-> scl_oe && !sda_oe; endproperty
   a_held: assert property (p_held) else $error("held bus wrong");
   property p_idle; !busy && !bus_held |-> !scl_oe && !sda_oe; endproperty
   a_idle: assert property (p_idle) else $error("idle lines pulled");
   property p_follow; bus_held && cmd_valid |-> cmd_ready; endproperty
   a_follow: assert property (p_follow) else $error("held bus refuses");
   property p_hold_ok; $rose(bus_held) |-> result; endproperty
   a_hold_ok: assert property (p_hold_ok) else $error("hold without ack");
   property p_fail; done && !result |-> !scl_oe && !sda_oe; endproperty
   a_fail: assert property (p_fail) else $error("failed without stop");
   property p_start; $rose(sda_oe) && !scl_oe |-> sda_oe throughout (##[1:START_WIN] scl_oe);
   endproperty
   a_start: assert property (p_start) else $error("start malformed");
   property p_stop; $fell(sda_oe) && !scl_oe |-> ##[1:STOP_WIN] done; endproperty
   a_stop: assert property (p_stop) else $error("stop not ending");
endmodule // ite_master_assertions

bind ite_master ite_master_assertions #(.QUARTER_CYCLES(QUARTER_CYCLES)) chk_u (
   .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .done(done), .result(result), .busy(busy), .bus_held(bus_held), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));

// ### verification/ite_master_tb.sv
`timescale 1ns/1ps
// Engine against one target on a pulled-up wired-AND bus
module ite_master_tb;
   logic                 clock, resetn, cmd_valid, buf_wr_en, tb_scl_pull, slv_pull;
   logic                 cmd_ready, done, result, busy, bus_held, scl_oe, sda_oe;
   logic [7:0]           buf_wr_index, buf_wr_data, buf_rd_index, buf_rd_data;
   ite_pkg::ite_cmd_type cmd;
   int                   miscompares, total_checks, s;
   wire                  scl_w = !(scl_oe || tb_scl_pull);
   wire                  sda_w = !(sda_oe || slv_pull);

   // Short quarter and timeout keep the run brief
   ite_master #(.QUARTER_CYCLES(4), .TIMEOUT_CYCLES(2000)) dut_u (
      .clock(clock), .resetn(resetn), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .done(done), .result(result), .busy(busy),
      .bus_held(bus_held), .buf_wr_en(buf_wr_en), .buf_wr_index(buf_wr_index),
      .buf_wr_data(buf_wr_data), .buf_rd_index(buf_rd_index), .buf_rd_data(buf_rd_data),
      .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
   ite_slave_model #(.ADDR(7'h2A)) slave_u (.scl(scl_w), .sda(sda_w), .sda_pull(slv_pull));

   always #2 clock = ~clock;

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %b", $time, what, got);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Offer a command, drop it once taken, wait for the end pulse
   task automatic run(input ite_pkg::ite_op_type op, input logic [6:0] a,
                      input logic [7:0] idx, input logic [8:0] n);
      int w;
      @(negedge clock);
      cmd = '{op: op, target_address: a, start_index: idx, count: n};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
      for (w = 0; w < 8000 && done !== 1'b1; w++) @(negedge clock);
      if (w == 8000) begin
         miscompares++;
         $display("[FAIL] %0t no end pulse", $time);
      end
   endtask

   task automatic bufw(input logic [7:0] i, input logic [7:0] d);
      @(negedge clock);
      buf_wr_en = 1'b1;
      buf_wr_index = i;
      buf_wr_data = d;
      @(negedge clock);
      buf_wr_en = 1'b0;
   endtask

   task automatic bufchk(input logic [7:0] i, input logic [7:0] d);
      @(negedge clock);
      buf_rd_index = i;
      @(negedge clock);
      cmp_byte(buf_rd_data, d, "stored byte");
   endtask

   task automatic t_write_hold();
      bufw(8'hFE, 8'h10);
      bufw(8'hFF, 8'hA5);
      bufw(8'h00, 8'h3C);
      run(ite_pkg::ITE_OP_WRITE, 7'h2A, 8'hFE, 9'h003);
      cmp_bit(result, 1'b1, "write result");
      cmp_bit(bus_held, 1'b1, "held");
      cmp_bit(scl_w, 1'b0, "clock held");
      cmp_bit(slave_u.last_rw, 1'b0, "write dir");
      cmp_byte(slave_u.mem[8'h10], 8'hA5, "sent 1");
      cmp_byte(slave_u.mem[8'h11], 8'h3C, "sent 2");
      $display("write_hold ended");
   endtask

   task automatic t_read_follow();
      slave_u.mem[8'h12] = 8'h5E;
      slave_u.ptr = 8'h10;
      run(ite_pkg::ITE_OP_READ, 7'h2A, 8'h40, 9'h003);
      cmp_bit(result, 1'b1, "read result");
      cmp_bit(slave_u.last_rw, 1'b1, "read dir");
      cmp_byte(8'(slave_u.acks), 8'h02, "master acks");
      cmp_bit(slave_u.got_nack, 1'b1, "last nack");
      cmp_byte(8'(slave_u.stops), 8'h01, "stop seen");
      cmp_bit(bus_held, 1'b0, "released");
      bufchk(8'h40, 8'hA5);
      bufchk(8'h41, 8'h3C);
      bufchk(8'h42, 8'h5E);
      $display("read_follow ended");
   endtask

   task automatic t_wrong_addr();
      for (int k = 0; k < 2; k++) begin
         s = slave_u.stops;
         run(k ? ite_pkg::ITE_OP_READ : ite_pkg::ITE_OP_WRITE, 7'h2B, 8'h00, 9'h001);
         cmp_bit(result, 1'b0, "nack result");
         cmp_byte(8'(slave_u.stops - s), 8'h01, "abandon stop");
         cmp_bit(bus_held, 1'b0, "not held");
      end
      $display("wrong_addr ended");
   endtask

   task automatic t_stop();
      run(ite_pkg::ITE_OP_WRITE, 7'h2A, 8'h00, 9'h000);
      cmp_bit(bus_held, 1'b1, "address only held");
      s = slave_u.stops;
      run(ite_pkg::ITE_OP_STOP, 7'h2A, 8'h00, 9'h000);
      cmp_byte(8'(slave_u.stops - s), 8'h01, "stop command");
      cmp_bit(bus_held, 1'b0, "stop releases");
      $display("stop ended");
   endtask

   task automatic t_timeout();
      fork
         run(ite_pkg::ITE_OP_WRITE, 7'h2A, 8'h00, 9'h001);
         begin
            // Ninth fall ends bit six; stall before the target can acknowledge
            repeat (9) @(negedge scl_w);
            @(negedge clock);
            tb_scl_pull = 1'b1;
         end
      join
      cmp_bit(result, 1'b0, "timeout result");
      @(negedge clock);
      tb_scl_pull = 1'b0;
      repeat (8) @(negedge clock);
      cmp_bit(sda_w && scl_w, 1'b1, "lines free");
      $display("timeout ended");
   endtask

   initial begin
      {clock, resetn, cmd_valid, buf_wr_en, tb_scl_pull} = 5'h00;
      {buf_wr_index, buf_wr_data, buf_rd_index} = 24'h000000;
      cmd = '0;
      repeat (20) @(negedge clock);
      resetn = 1'b1;
      t_write_hold();
      t_read_follow();
      t_wrong_addr();
      t_stop();
      t_timeout();
      conclude();
   end

   // Watchdog; the whole sequence needs well under 60 us
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule // ite_master_tb

// ### verification/ite_slave_model.sv
`timescale 1ns/1ps
// Behavioural target; first written byte loads its pointer
module ite_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A  // Own bus address
) (
   input  wire logic scl,      // Clock line level
   input  wire logic sda,      // Data line level
   output logic      sda_pull  // High pulls data line low
);
   logic [7:0] mem [0:255];
   logic [7:0] ptr;
   logic [6:0] last_addr;
   logic       last_rw;
   logic       got_nack;
   int         acks;
   int         stops;
   bit         by_stop;

   task automatic recv(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge scl) b = {b[6:0], sda};
      end
   endtask

   task automatic serve();
      logic [7:0] b;
      bit         first;
      first = 1'b1;
      recv(b);
      last_addr = b[7:1];
      last_rw = b[0];
      @(negedge scl) sda_pull = (b[7:1] == ADDR);
      if (b[7:1] != ADDR) wait (1'b0);
      if (!last_rw) forever begin
         @(negedge scl) sda_pull = 1'b0;
         recv(b);
         if (!first) mem[ptr++] = b;
         else ptr = b;
         first = 1'b0;
         @(negedge scl) sda_pull = 1'b1;
      end
      forever begin
         for (int i = 7; i >= 0; i--) begin
            @(negedge scl) sda_pull = !mem[ptr][i];
         end
         @(negedge scl) sda_pull = 1'b0;
         ptr++;
         @(posedge scl);
         got_nack = sda;
         if (sda) wait (1'b0);
         acks++;
      end
   endtask

   // Frames end on STOP; a repeated START restarts decoding
   initial begin
      sda_pull = 1'b0;
      got_nack = 1'b0;
      acks = 0;
      stops = 0;
      forever begin
         @(negedge sda iff scl === 1'b1);
         by_stop = 1'b0;
         while (!by_stop) begin
            fork : frame
               begin
                  @(posedge sda iff scl === 1'b1);
                  by_stop = 1'b1;
               end
               @(negedge sda iff scl === 1'b1);
               serve();
            join_any
            disable fork;
            sda_pull = 1'b0;
         end
         stops++;
      end
   end
endmodule // ite_slave_model
